/* sdep_port.sv */
// serial command port of a twelve channel d/a with io expander
// assumes cs, sclk, sdi and parallel pins are asynchronous to clk_in
// and that the serial clock is far slower than clk_in
// every pin edge is seen about three clocks late, so results and the
// serial output trail the pins by that much
`timescale 1ns/10ps
// Behaviour
// [RL1] bits are accepted only after chip select falls
// [RL2] sixteen bits per frame; command runs at chip select rise
// [RL3] converter command loads the addressed channel code at rise
// [RL4] expander output command drives the output pins at rise
// [RL5] setup write latches pin directions at rise
// [RL6] parallel-to-serial command is accepted at chip select rise
// [RL7] next chip select fall captures input pins into bits 4..15
// [RL8] captured bits leave serial output on falling clock edges
// [RL9] input sampled on rising clock edges while chip select low
module sdep_port
#(
  parameter int NCH = sdep_pkg::CHANNELS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic [sdep_pkg::PAR_W-1:0] par_in,
  output logic so_out,
  output logic so_oe_out,
  output logic [sdep_pkg::PAR_W-1:0] par_out,
  output logic [sdep_pkg::PAR_W-1:0] par_oe_out,
  output logic [NCH*sdep_pkg::CODE_W-1:0] dac_code_out,
  output logic [sdep_pkg::PAR_W-1:0] setup_out
);
  import sdep_pkg::*;

  logic [2:0] pins_s;
  logic [PAR_W-1:0] par_s;
  logic cs_d;
  logic sclk_d;
  sdep_state_t state;
  sdep_state_t next_state;
  logic [FRAME_BITS-1:0] sr;
  logic [FRAME_BITS-1:0] so_sr;
  logic [CNT_W-1:0] cnt;
  logic capture_pend;
  logic [CODE_W-1:0] code [NCH];

  // ===========================================================
  // edge helpers: one level compare per direction, shared by both
  // pins, so the two detectors of each direction cannot drift apart
  function automatic logic went_low(input logic was, input logic now);
    return was && !now;
  endfunction

  function automatic logic went_high(input logic was, input logic now);
    return !was && now;
  endfunction

  // ===========================================================
  // synchronisers: cs idles high, so it resets high
  sdep_sync #(.WIDTH(3)) u_pins (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({cs_n_in, sclk_in, sdi_in}),
    .rst_val_in(3'b100),
    .sync_out(pins_s)
  );

  sdep_sync #(.WIDTH(PAR_W)) u_par (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(par_in),
    .rst_val_in(SETUP_RST),
    .sync_out(par_s)
  );

  // ===========================================================
  // edge detection and command decode
  wire cs_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire sdi_s = pins_s[0];
  wire cs_fall = went_low(cs_d, cs_s); // [RL1]
  wire cs_rise = went_high(cs_d, cs_s);
  wire sclk_rise = went_high(sclk_d, sclk_s) && !cs_s; // [RL9]
  wire sclk_fall = went_low(sclk_d, sclk_s) && !cs_s;
  wire [OP_W-1:0] op = sr[OP_LSB +: OP_W];
  wire [PAR_W-1:0] data = sr[DATA_LSB +: PAR_W];
  // short or long frames are dropped: the shift register holds junk
  wire frame_ok = (cnt == CNT_W'(FRAME_BITS)); // [RL2]
  wire exec = cs_rise && (state == SDEP_FRAME) && frame_ok; // [RL2]
  wire is_dac = (op >= OP_DAC_FIRST) && (op <= OP_DAC_LAST);
  wire [OP_W-1:0] ch = op - OP_DAC_FIRST;
  // a narrower build ignores channels it does not have
  wire ch_ok = (int'(ch) < NCH);
  wire do_par_out = exec && (op == OP_PAR_OUT);
  wire do_setup = exec && (op == OP_SETUP);
  wire do_par_in = exec && (op == OP_PAR_IN); // [RL6]

  // ===========================================================
  // frame tracker
  always_comb begin
    next_state = state;
    case (state)
      SDEP_IDLE: begin
        if (cs_fall) begin
          next_state = SDEP_FRAME;
        end
      end
      SDEP_FRAME: begin
        if (cs_rise) begin
          next_state = SDEP_IDLE;
        end
      end
      default: begin
        next_state = SDEP_IDLE;
      end
    endcase
  end

  // ===========================================================
  // delayed levels, state and bit counter (saturates)
  // saturating one past sixteen keeps a long frame from wrapping
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
      state <= SDEP_IDLE;
      cnt <= CNT_RST;
    end else begin
      cs_d <= cs_s;
      sclk_d <= sclk_s;
      state <= next_state;
      if (cs_fall) begin
        cnt <= CNT_RST;
      end else if (sclk_rise && cnt <= CNT_W'(FRAME_BITS)) begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // input shift register, first bit ends in bit 15
  // only inside a frame, so a stray clock between frames shifts nothing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sr <= SR_RST;
    end else if (sclk_rise && state == SDEP_FRAME) begin
      sr <= {sr[FRAME_BITS-2:0], sdi_s}; // [RL9]
    end
  end

  // ===========================================================
  // parallel capture armed by the command, taken at next cs fall
  // pins are sampled after their sync, so they must settle before it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      capture_pend <= 1'b0;
      so_sr <= SR_RST;
    end else begin
      if (do_par_in) begin
        capture_pend <= 1'b1; // [RL6]
      end else if (cs_fall) begin
        capture_pend <= 1'b0;
      end
      if (cs_fall && capture_pend) begin
        so_sr <= {par_s, OP_NOP}; // [RL7]
      end else if (sclk_fall) begin
        so_sr <= {so_sr[FRAME_BITS-2:0], 1'b0}; // [RL8]
      end
    end
  end

  // serial output: driven only inside a frame
  // floating between frames lets another device share the line
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= !cs_s;
      if (cs_fall && capture_pend) begin
        so_out <= par_s[PAR_W-1]; // [RL7]
      end else if (sclk_fall) begin
        so_out <= so_sr[FRAME_BITS-2]; // [RL8]
      end
    end
  end

  // ===========================================================
  // expander outputs and setup register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      par_out <= DOUT_RST;
      setup_out <= SETUP_RST;
      par_oe_out <= SETUP_RST;
    end else begin
      if (do_par_out) begin
        par_out <= data; // [RL4]
      end
      if (do_setup) begin
        setup_out <= data; // [RL5]
        par_oe_out <= data; // [RL5]
      end
    end
  end

  // ===========================================================
  // converter codes, one register per channel
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NCH; i++) begin
        code[i] <= CODE_RST;
      end
    end else if (exec && is_dac && ch_ok) begin
      code[ch] <= data[CODE_W-1:0]; // [RL3]
    end
  end

  // flatten the code registers onto the output bus
  // plain wiring: every slice still comes straight from a flip-flop
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      dac_code_out[i*CODE_W +: CODE_W] = code[i];
    end
  end
endmodule

/* sdep_pkg.sv */
// constants for the serial converter and expander command port
// assumes the users import it whole; no logic lives here
package sdep_pkg;

  // ===========================================================
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int OP_LSB = 0;
  localparam int OP_W = 4;
  localparam int DATA_LSB = 4;
  localparam int PAR_W = 12;
  localparam int CODE_W = 8;
  localparam int CHANNELS = 12;
  localparam int CNT_W = 5;

  // ===========================================================
  // command codes in frame bits 3:0
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_DAC_FIRST = 4'h1;
  localparam logic [3:0] OP_DAC_LAST = 4'hc;
  localparam logic [3:0] OP_PAR_OUT = 4'hd;
  localparam logic [3:0] OP_SETUP = 4'he;
  localparam logic [3:0] OP_PAR_IN = 4'hf;

  // ===========================================================
  // reset values: codes at zero, pins inputs, outputs low
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [11:0] SETUP_RST = 12'h000;
  localparam logic [11:0] DOUT_RST = 12'h000;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [15:0] SR_RST = 16'h0000;

  // frame tracker, gray coded along idle -> frame -> idle
  typedef enum logic [1:0] {
    SDEP_IDLE = 2'b00,
    SDEP_FRAME = 2'b01
  } sdep_state_t;

endpackage

/* sdep_sync.sv */
// two flip-flop synchroniser for a bundle of pin levels
// assumes the inputs are asynchronous to clk_in
`timescale 1ns/10ps
module sdep_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_val_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] held;

  // ===========================================================
  // both stages hold the level xor its idle value, so a cleared pair
  // reads back as the idle level and no false edge follows reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= '0;
      held <= '0;
    end else begin
      meta <= async_in ^ rst_val_in;
      held <= meta;
    end
  end

  // undo the inversion; only the second stage is read
  assign sync_out = held ^ rst_val_in;
endmodule

/* sdep_port_properties.sv */
// checker for the serial command port, watching its pins only
// assumes a bind onto every sdep_port instance
`timescale 1ns/10ps
module sdep_port_properties #(
  parameter int NCH = 12
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic [sdep_pkg::PAR_W-1:0] par_out,
  input wire logic [sdep_pkg::PAR_W-1:0] par_oe_out,
  input wire logic [NCH*sdep_pkg::CODE_W-1:0] dac_code_out,
  input wire logic [sdep_pkg::PAR_W-1:0] setup_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ============================================================
  // results only land once chip select is back high
  a_code_at_rise: assert property (
    !$stable(dac_code_out) |-> cs_n_in && $past(cs_n_in, 2))
    else $error("code changed inside a frame");
  a_pins_at_rise: assert property (
    !$stable(par_out) |-> cs_n_in && $past(cs_n_in, 2))
    else $error("expander output changed inside a frame");
  a_setup_at_rise: assert property (
    !$stable(setup_out) |-> cs_n_in && $past(cs_n_in, 2))
    else $error("setup changed inside a frame");
  a_dir_follows_setup: assert property (
    par_oe_out == setup_out)
    else $error("pin enables differ from setup");
  // ============================================================
  // serial output drive follows the frame, sync lag is three clocks
  a_oe_at_fall: assert property (
    $fell(cs_n_in) |-> ##[2:5] so_oe_out)
    else $error("serial output not enabled after select");
  a_oe_held: assert property (
    !cs_n_in [*6] |-> so_oe_out)
    else $error("serial output dropped inside a frame");
  a_oe_release: assert property (
    $rose(cs_n_in) |-> ##[2:5] !so_oe_out)
    else $error("serial output kept after deselect");
  // data may only move while the serial clock is low, now and two clocks before
  a_so_on_fall: assert property (
    !$stable(so_out) |-> !sclk_in && !$past(sclk_in, 2))
    else $error("serial output moved with clock high");
  cover property ($fell(so_oe_out));
  cover property (!$stable(setup_out));
  cover property (!$stable(so_out));
endmodule

bind sdep_port sdep_port_properties #(.NCH(NCH)) sdep_port_properties_inst (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
  .so_out(so_out), .so_oe_out(so_oe_out), .par_out(par_out),
  .par_oe_out(par_oe_out), .dac_code_out(dac_code_out),
  .setup_out(setup_out));

/* sdep_host.sv */
// host model: frames commands on select, serial clock and data
// assumes 160 ns serial clock, idle low between frames
`timescale 1ns/10ps
module sdep_host (
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input wire logic so_in
);
  logic [15:0] got = 16'h0000;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // msb first; the reply is taken just before each falling edge
  task automatic send(input logic [15:0] w, input int n);
    cs_n_out = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sdi_out = w[15-i];
      #80 sclk_out = 1'b1;
      #80 got = {got[14:0], so_in};
      sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // released line shows no stale bit
    #100;
  endtask
endmodule

/* sdep_port_bench.sv */
// bench for the serial command port driven by the host model
// assumes package, design, host model and checker compiled first
`timescale 1ns/10ps
module sdep_port_bench;
  import sdep_pkg::*;
  logic clk_in, rst_in, cs_n, sclk, sdi, so, so_oe;
  logic [PAR_W-1:0] par_in, par_out, par_oe, setup;
  logic [CHANNELS*CODE_W-1:0] codes, exp_codes;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  sdep_port sdep_port_inst (.clk_in(clk_in), .rst_in(rst_in),
    .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .par_in(par_in),
    .so_out(so), .so_oe_out(so_oe), .par_out(par_out),
    .par_oe_out(par_oe), .dac_code_out(codes), .setup_out(setup));
  sdep_host sdep_host_inst (.cs_n_out(cs_n), .sclk_out(sclk),
    .sdi_out(sdi), .so_in(so));
  // ============================================================
  // compare and report
  task automatic chk(input string nm, input logic [95:0] e,
    input logic [95:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ============================================================
  // scenarios
  // every channel op once; one vector check catches a wrong channel
  task automatic t_dac;
    exp_codes = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      exp_codes[ch*8+:8] = 8'h3a + 8'(ch * 17);
      sdep_host_inst.send({4'h0, exp_codes[ch*8+:8], 4'(ch + 1)},
        16);
    end
    chk("dac codes", exp_codes, codes);
  endtask
  // a short frame run anyway would decode as a setup write
  task automatic t_par_out;
    sdep_host_inst.send(16'ha5cd, 16);
    chk("expander out", 96'ha5c, par_out);
    sdep_host_inst.send(16'h0ffd, 15);
    chk("short frame", 96'ha5c, par_out);
    chk("short frame setup", 96'h0, setup);
  endtask
  task automatic t_setup;
    sdep_host_inst.send(16'h3c1e, 16);
    chk("setup and enables", {12'h3c1, 12'h3c1}, {setup, par_oe});
  endtask
  // pins change between arming and capture to expose an early grab
  task automatic t_capture;
    sdep_host_inst.send(16'h000f, 16);
    @(posedge clk_in);
    #1 par_in = 12'h6c9;
    sdep_host_inst.send(16'h0000, 16);
    chk("captured bits", {12'h6c9, 4'h0}, sdep_host_inst.got);
    chk("codes after nop", exp_codes, codes);
    chk("pins after nop", 96'ha5c, par_out);
  endtask
  // ============================================================
  // clock, timeout and sequence
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // frames take about 700 clocks; 20000 leaves ample margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    rst_in = 1'b1;
    par_in = 12'hb37;
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    chk("reset codes", 96'h0, codes);
    chk("reset pins", 96'h0, {so_oe, par_out, par_oe, setup});
    t_dac;
    t_par_out;
    t_setup;
    t_capture;
    wrap_up;
  end
endmodule
